// file: tec_array_props.sv
// tec_array_props.sv: port-level checks of the event counter array
// assumes one clock domain and the async active-low reset of the top
`timescale 1ns/1ns
module tec_array_props
#(
	parameter NUM = 16,
	parameter W = 32
)
(
	// clock and reset
	input wire i_clk,
	input wire i_nrst,
	// software access and setup
	input wire i_wr_en,
	input wire [3:0] i_wr_idx,
	input wire [W-1:0] i_wr_data,
	input wire [3:0] i_rd_idx,
	input wire [31:0] i_profile_cfg,
	input wire [31:0] i_counter_source_select,
	// results
	input wire [W-1:0] o_rd_data,
	input wire [NUM-1:0] o_trigger_flags,
	input wire o_exception_pending_bits_counter
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);
	// enable of the counter being read
	wire en_rd;
	assign en_rd = i_profile_cfg[16 + i_rd_idx];
	a_irq_on_trig: assert property ((|o_trigger_flags) |=>
		o_exception_pending_bits_counter) else $error("irq missing");
	a_irq_quiet: assert property (!(|o_trigger_flags) |=>
		!o_exception_pending_bits_counter) else $error("irq spurious");
	a_write_clears: assert property (i_wr_en |=>
		!o_trigger_flags[$past(i_wr_idx)]) else $error("trigger kept");
	a_trig_sticky: assert property (($past(o_trigger_flags) &
		~o_trigger_flags & ~($past(i_wr_en) ? ({{(NUM-1){1'b0}}, 1'b1}
		<< $past(i_wr_idx)) : {NUM{1'b0}})) == {NUM{1'b0}})
		else $error("trigger dropped");
	a_wr_readback: assert property (i_wr_en ##1
		(i_rd_idx == $past(i_wr_idx)) |=> o_rd_data ==
		$past(i_wr_data, 2)) else $error("written value lost");
	a_hold_idle: assert property (!i_wr_en && !en_rd &&
		i_rd_idx != 4'hA ##1 ($stable(i_rd_idx) && !i_wr_en && !en_rd)
		|=> $stable(o_rd_data))
		else $error("disabled counter moved");
	a_cycle_step: assert property (i_rd_idx == 4'h0 && !i_wr_en &&
		i_profile_cfg[16] && !i_counter_source_select[25] ##1
		($stable(i_rd_idx) && !i_wr_en && i_profile_cfg[16] &&
		!i_counter_source_select[25]) |=>
		o_rd_data == $past(o_rd_data) - 1'b1)
		else $error("cycle count step wrong");
	a_wrap_trig: assert property (!i_wr_en ##1
		($stable(i_rd_idx) && !i_wr_en) ##1 (o_rd_data == {W{1'b1}} &&
		$past(o_rd_data) == {W{1'b0}}) |-> o_trigger_flags[$past(i_rd_idx,
		2)]) else $error("wrap without trigger");
	// main scenarios reached
	c_irq: cover property ((|o_trigger_flags) ##1
		o_exception_pending_bits_counter);
	c_clear: cover property (i_wr_en && (|o_trigger_flags));
	c_single: cover property (i_profile_cfg[0]);
endmodule // tec_array_props
bind tec_counter_array tec_array_props #(.NUM(NUM), .W(W)) u_props
(
	.i_clk(i_clk), .i_nrst(i_nrst), .i_wr_en(i_wr_en),
	.i_wr_idx(i_wr_idx), .i_wr_data(i_wr_data), .i_rd_idx(i_rd_idx),
	.i_profile_cfg(i_profile_cfg),
	.i_counter_source_select(i_counter_source_select),
	.o_rd_data(o_rd_data), .o_trigger_flags(o_trigger_flags),
	.o_exception_pending_bits_counter(o_exception_pending_bits_counter)
);

// file: tec_cell.v
// tec_cell.v: one 32-bit down-counting event counter with sticky trigger
// assumes a single clock; write and event strobes one cycle each
`timescale 1ns/1ns
`include "tec_defs.vh"
module tec_cell
#(
	parameter W = `TEC_CNT_W
)
(
	// clock and reset
	input wire i_clk,
	input wire i_nrst,
	// event side
	input wire i_event,
	input wire i_pc_valid,
	input wire [`TEC_PCF_W-1:0] i_pc_field,
	input wire i_lfsr_mode,
	// software write
	input wire i_wr,
	input wire [W-1:0] i_wr_data,
	// state
	output reg [W-1:0] o_value,
	output reg o_trigger
);
	reg [W-1:0] next_value; // value after this edge
	reg [W-1:0] dec; // decremented value
	reg next_trigger; // trigger after this edge
	// next state; a write overrides any event of the same cycle
	always @*
	begin
		dec = o_value - {{(W-1){1'b0}}, 1'b1};
		next_value = o_value;
		next_trigger = o_trigger;
		if (i_wr)
		begin
			next_value = i_wr_data;
			next_trigger = 1'b0;
		end
		else if (i_lfsr_mode)
			next_value = {o_value[31] ^ o_value[30] ^ o_value[10] ^
				o_value[0], o_value[W-1:1]};
		else if (i_event)
		begin
			// keeps counting even once triggered
			next_value = dec;
			if (i_pc_valid)
				next_value[W-1:`TEC_PCF_LSB] = i_pc_field;
			if (o_value == {W{1'b0}})
				next_trigger = 1'b1;
		end
	end
	// state registers
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_value <= `TEC_CNT_RST;
			o_trigger <= 1'b0;
		end
		else
		begin
			o_value <= next_value;
			o_trigger <= next_trigger;
		end
	end
endmodule // tec_cell

// file: tec_counter_array.v
// tec_counter_array.v: sixteen event counters of a processor tile
// assumes event strobes and pcs synchronous to i_clk, one cycle each
// Contract
// - sixteen independent 32-bit counter cells
// - decrement by one per selected event
// - 0 to -1 sets trigger until write
// - triggers readable, ORed into interrupt bit
// - causing pc into bits 31:16
// - keep counting while trigger set
// - software reads/writes counters; write clears trigger
// - read sees event next cycle; interrupt two; code raises it with the read
// - pc-free events ignore single-instruction mode
// - counter 0 cycles or write-over-read
// - counters 1-3 writebacks, fills, cache stalls
// - counter 4 memory ops or fpu ops
// - counter 5 possible mispredicts, hint variant
// - counter 6 actual mispredicts, hint variant
// - counters 7-9 switch events, switch pc
// - counter 10 is a 32-bit lfsr
// - counter 11 union of enabled sources
// - counter 12 enabled sources, rf pc
// - counter 13 enabled sources
// - counter 14 output stalls and east ports
// - counter 15 input-empty stalls
// - single-pc profile mode and per-counter enables
// - select bits choose counted subset
`timescale 1ns/1ns
`include "tec_defs.vh"
module tec_counter_array
#(
	parameter NUM = `TEC_NUM,
	parameter W = `TEC_CNT_W
)
(
	// clock and reset
	input wire i_clk,
	input wire i_nrst,
	// configuration
	input wire [31:0] i_counter_source_select,
	input wire [31:0] i_profile_cfg,
	// software access
	input wire i_wr_en,
	input wire [3:0] i_wr_idx,
	input wire [W-1:0] i_wr_data,
	input wire [3:0] i_rd_idx,
	// stage pcs
	input wire [31:0] i_pc_rf,
	input wire [31:0] i_pc_exe,
	input wire [31:0] i_pc_mem,
	input wire [31:0] i_pc_fpu,
	input wire [31:0] i_switch_pc,
	// cache events
	input wire i_write_over_read,
	input wire i_cache_writeback,
	input wire i_cache_fill,
	input wire i_cache_stall,
	// execute events
	input wire i_mem_op,
	input wire i_fpu_op,
	input wire i_cond_branch,
	input wire i_ret_or_register_jump,
	input wire i_hint_wrong_branch,
	input wire i_mispredict,
	input wire i_hint_mispredict,
	input wire i_instr_issued,
	// switch events
	input wire i_switch_stall,
	input wire i_switch_possible_mispredict,
	input wire i_switch_mispredict,
	// register-fetch stalls
	input wire i_func_unit_stall,
	input wire i_noncache_stall,
	input wire i_imem_op_issued,
	input wire i_static_output_stall,
	input wire i_general_net_output_stall,
	input wire i_memory_net_output_stall,
	input wire i_static_input_stall,
	input wire i_second_static_input_stall,
	input wire i_general_net_input_stall,
	input wire i_memory_net_input_stall,
	// network port events
	input wire i_general_proc_port_count,
	input wire i_memory_proc_port_count,
	input wire i_general_west_port_count,
	input wire i_memory_west_port_count,
	input wire i_general_south_port_count,
	input wire i_memory_south_port_count,
	input wire i_general_east_port_count,
	input wire i_memory_east_port_count,
	// results
	output reg [W-1:0] o_rd_data,
	output wire [NUM-1:0] o_trigger_flags,
	output reg o_exception_pending_bits_counter
);
	wire [31:0] sel; // short alias of the source select word
	reg [NUM-1:0] pc_ev; // pc-tied raw strobes per counter
	reg [NUM-1:0] free_ev; // pc-free raw strobes per counter
	reg [NUM-1:0] pc_valid; // pc field should be captured
	reg [NUM*32-1:0] pc_bus; // causing pc per counter
	wire [NUM-1:0] ev; // filtered strobes
	wire [NUM*W-1:0] val_bus; // counter values
	wire [NUM-1:0] trig; // sticky triggers
	wire [NUM-1:0] lfsr_mode; // counter runs as lfsr
	reg [NUM-1:0] wr_hit; // one-hot write strobe
	integer k; // loop index

	assign sel = i_counter_source_select;

	// write decode; index width covers all sixteen cells
	always @*
	begin
		for (k = 0; k < NUM; k = k + 1)
			wr_hit[k] = i_wr_en && (i_wr_idx == k[3:0]);
	end

	// per-counter event selection
	always @*
	begin
		pc_ev = {NUM{1'b0}};
		free_ev = {NUM{1'b0}};
		pc_valid = {NUM{1'b0}};
		pc_bus = {NUM*32{1'b0}};
		// counter 0: free-running cycles or write-over-read
		if (sel[`TEC_SEL_WOR])
		begin
			pc_ev[0] = i_write_over_read;
			pc_valid[0] = 1'b1;
		end
		else
			free_ev[0] = 1'b1;
		pc_bus[0*32 +: 32] = i_pc_fpu;
		// counters 1..3: memory-stage cache events
		pc_ev[1] = i_cache_writeback;
		pc_ev[2] = i_cache_fill;
		pc_ev[3] = i_cache_stall;
		pc_valid[3:1] = 3'h7;
		pc_bus[1*32 +: 32] = i_pc_mem;
		pc_bus[2*32 +: 32] = i_pc_mem;
		pc_bus[3*32 +: 32] = i_pc_mem;
		// counter 4: memory ops or fpu ops
		pc_ev[4] = sel[`TEC_SEL_FPU] ? i_fpu_op : i_mem_op;
		pc_valid[4] = 1'b1;
		pc_bus[4*32 +: 32] = i_pc_exe;
		// counter 5: possible mispredicts
		if (sel[`TEC_SEL_HINT_POSS])
			pc_ev[5] = i_hint_wrong_branch;
		else
			pc_ev[5] = i_cond_branch | i_ret_or_register_jump;
		pc_valid[5] = 1'b1;
		pc_bus[5*32 +: 32] = i_pc_exe;
		// counter 6: actual mispredicts
		pc_ev[6] = sel[`TEC_SEL_HINT_ACT] ? i_hint_mispredict :
			i_mispredict;
		pc_valid[6] = 1'b1;
		pc_bus[6*32 +: 32] = i_pc_exe;
		// counters 7..9: switch processor, never pc filtered
		free_ev[7] = i_switch_stall;
		free_ev[8] = i_switch_possible_mispredict;
		free_ev[9] = i_switch_mispredict;
		pc_valid[9:7] = 3'h7;
		pc_bus[7*32 +: 32] = i_switch_pc;
		pc_bus[8*32 +: 32] = i_switch_pc;
		pc_bus[9*32 +: 32] = i_switch_pc;
		// counter 10 needs no strobe: it shifts every cycle without a write
		// counter 11: union of enabled sources
		pc_ev[11] = sel[`TEC_SEL_FU_STALL] & i_func_unit_stall;
		free_ev[11] =
			(sel[`TEC_SEL_GP] & i_general_proc_port_count) |
			(sel[`TEC_SEL_MP] & i_memory_proc_port_count) |
			(sel[`TEC_SEL_ISSUE1] & i_instr_issued);
		pc_valid[11] = pc_ev[11];
		pc_bus[11*32 +: 32] = i_pc_rf;
		// counter 12: non-cache stalls and west ports
		pc_ev[12] = sel[`TEC_SEL_NONCACHE] & i_noncache_stall;
		free_ev[12] =
			(sel[`TEC_SEL_GW] & i_general_west_port_count) |
			(sel[`TEC_SEL_MW] & i_memory_west_port_count);
		pc_valid[12] = pc_ev[12];
		pc_bus[12*32 +: 32] = i_pc_rf;
		// counter 13: imem ops, south ports, issued instructions
		pc_ev[13] = sel[`TEC_SEL_IMEM_OP] & i_imem_op_issued;
		free_ev[13] =
			(sel[`TEC_SEL_GS] & i_general_south_port_count) |
			(sel[`TEC_SEL_MS] & i_memory_south_port_count) |
			(sel[`TEC_SEL_ISSUE2] & i_instr_issued);
		pc_valid[13] = pc_ev[13];
		pc_bus[13*32 +: 32] = i_pc_rf;
		// counter 14: blocked outputs and east ports
		pc_ev[14] =
			(sel[`TEC_SEL_STO] & i_static_output_stall) |
			(sel[`TEC_SEL_GNO] & i_general_net_output_stall) |
			(sel[`TEC_SEL_MNO] & i_memory_net_output_stall);
		free_ev[14] =
			(sel[`TEC_SEL_GE] & i_general_east_port_count) |
			(sel[`TEC_SEL_ME] & i_memory_east_port_count);
		pc_valid[14] = pc_ev[14];
		pc_bus[14*32 +: 32] = i_pc_rf;
		// counter 15: empty inputs
		pc_ev[15] =
			(sel[`TEC_SEL_STI] & i_static_input_stall) |
			(sel[`TEC_SEL_STI2] & i_second_static_input_stall) |
			(sel[`TEC_SEL_GNI] & i_general_net_input_stall) |
			(sel[`TEC_SEL_MNI] & i_memory_net_input_stall);
		pc_valid[15] = 1'b1;
		pc_bus[15*32 +: 32] = i_pc_rf;
	end

	// one filter and one cell per counter
	genvar g;
	generate
		for (g = 0; g < NUM; g = g + 1)
		begin : gen_cell
			assign lfsr_mode[g] = (g == `TEC_LFSR_IDX);
			// filter: profile match and per-counter enable
			tec_prof_gate u_gate
			(
				.i_pc_event(pc_ev[g]),
				.i_free_event(free_ev[g]),
				.i_pc(pc_bus[g*32 +: 32]),
				.i_cfg(i_profile_cfg),
				.i_enable(i_profile_cfg[`TEC_CFG_EN_LSB + g]),
				.o_event(ev[g])
			);
			// counter cell; pc bits 1:0 are always zero, so dropped
			tec_cell #(.W(W)) u_cell
			(
				.i_clk(i_clk),
				.i_nrst(i_nrst),
				.i_event(ev[g]),
				.i_pc_valid(pc_valid[g]),
				.i_pc_field(pc_bus[g*32+2 +: `TEC_PCF_W]),
				.i_lfsr_mode(lfsr_mode[g]),
				.i_wr(wr_hit[g]),
				.i_wr_data(i_wr_data),
				.o_value(val_bus[g*W +: W]),
				.o_trigger(trig[g])
			);
		end
	endgenerate

	// trigger flags come straight from the cell flip-flops
	assign o_trigger_flags = trig;

	// read port and interrupt request; both one register stage
	// event at edge n lands in the cell, so read shows it next
	always @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			o_rd_data <= `TEC_CNT_RST;
			o_exception_pending_bits_counter <= 1'b0;
		end
		else
		begin
			o_rd_data <= val_bus[i_rd_idx*W +: W];
			// same stage: interrupt one edge after the trigger sets, with the read
			o_exception_pending_bits_counter <= |trig;
		end
	end
endmodule // tec_counter_array

// file: tec_defs.vh
// tec_defs.vh: constants of the tile event counter array
// assumes inclusion by bare name from the tec design files
`ifndef TEC_DEFS_VH
`define TEC_DEFS_VH
// counter geometry
`define TEC_NUM 16
`define TEC_CNT_W 32
`define TEC_CNT_RST 32'h00000000
`define TEC_PCF_LSB 16
`define TEC_PCF_W 16
`define TEC_LFSR_IDX 10
// profile configuration fields
`define TEC_CFG_SINGLE 0
`define TEC_CFG_PC_LSB 1
`define TEC_CFG_PC_MSB 15
`define TEC_CFG_EN_LSB 16
// source select bit positions
`define TEC_SEL_FPU 0
`define TEC_SEL_HINT_POSS 1
`define TEC_SEL_HINT_ACT 2
`define TEC_SEL_FU_STALL 3
`define TEC_SEL_GP 4
`define TEC_SEL_MP 5
`define TEC_SEL_NONCACHE 6
`define TEC_SEL_GW 7
`define TEC_SEL_MW 8
`define TEC_SEL_IMEM_OP 9
`define TEC_SEL_GS 10
`define TEC_SEL_MS 11
`define TEC_SEL_STO 12
`define TEC_SEL_GNO 13
`define TEC_SEL_MNO 14
`define TEC_SEL_GE 15
`define TEC_SEL_ME 16
`define TEC_SEL_STI 17
`define TEC_SEL_STI2 18
`define TEC_SEL_GNI 19
`define TEC_SEL_MNI 20
`define TEC_SEL_ISSUE1 23
`define TEC_SEL_ISSUE2 24
`define TEC_SEL_WOR 25
`endif

// file: tec_prof_gate.v
// tec_prof_gate.v: single-instruction profiling filter for one counter
// assumes pc-tied and pc-free event strobes of the same cycle
`timescale 1ns/1ns
`include "tec_defs.vh"
module tec_prof_gate
(
	// event strobes
	input wire i_pc_event,
	input wire i_free_event,
	// pc of the causing instruction and profile setup
	input wire [31:0] i_pc,
	input wire [31:0] i_cfg,
	input wire i_enable,
	// filtered strobe
	output wire o_event
);
	wire single; // single-instruction mode on
	wire match; // pc bits 16:2 equal the profiled pc field
	assign single = i_cfg[`TEC_CFG_SINGLE];
	assign match = (i_pc[16:2] == i_cfg[`TEC_CFG_PC_MSB:`TEC_CFG_PC_LSB]);
	// pc-free sources bypass the pc filter
	assign o_event = i_enable &
		((i_pc_event & (~single | match)) | i_free_event);
endmodule // tec_prof_gate

// file: tec_src_model.sv
// tec_src_model.sv: event source pipeline model feeding the counter array
// assumes the bench raises requests just after a falling clock edge
`timescale 1ns/1ns
module tec_src_model
(
	// clock
	input wire i_clk,
	// requests from the bench
	input wire [32:0] i_req,
	input wire [31:0] i_pc,
	// strobes and stage pc toward the counters
	output wire [32:0] o_ev,
	output wire [31:0] o_pc
);
	// filler pc flips every cycle so a stale pc never looks valid
	reg [31:0] junk = 32'h0;
	// free-running filler
	always @(posedge i_clk)
		junk <= ~junk;
	// one strobe per requested cycle
	assign o_ev = i_req;
	// pc only holds meaning in a strobe cycle
	assign o_pc = (|i_req) ? i_pc : junk;
endmodule // tec_src_model

// file: test_tile_event_counter_array.sv
// test_tile_event_counter_array.sv: self-checking bench of the counters
// assumes tec_src_model drives every event strobe and stage pc
`timescale 1ns/1ns
module test_tile_event_counter_array;
	reg clk;
	reg nrst;
	reg wr_en;
	reg [3:0] wr_idx;
	reg [3:0] rd_idx;
	reg [31:0] sel;
	reg [31:0] cfg;
	reg [31:0] wr_data;
	reg [31:0] pc;
	reg [32:0] req;
	wire [32:0] ev;
	wire [31:0] spc;
	wire [31:0] rd;
	wire [15:0] flags;
	wire irq;
	integer n_fail = 0;
	integer compares = 0;
	tec_src_model src (.i_clk(clk), .i_req(req), .i_pc(pc), .o_ev(ev),
		.o_pc(spc));
	tec_counter_array dut
	(
		.i_clk(clk), .i_nrst(nrst), .i_counter_source_select(sel),
		.i_profile_cfg(cfg), .i_wr_en(wr_en), .i_wr_idx(wr_idx),
		.i_wr_data(wr_data), .i_rd_idx(rd_idx), .i_pc_rf(spc),
		.i_pc_exe(spc), .i_pc_mem(spc), .i_pc_fpu(spc), .i_switch_pc(spc),
		.i_write_over_read(ev[0]), .i_cache_writeback(ev[1]),
		.i_cache_fill(ev[2]), .i_cache_stall(ev[3]), .i_mem_op(ev[4]),
		.i_fpu_op(ev[5]), .i_cond_branch(ev[6]),
		.i_ret_or_register_jump(ev[7]), .i_hint_wrong_branch(ev[8]),
		.i_mispredict(ev[9]), .i_hint_mispredict(ev[10]),
		.i_instr_issued(ev[11]), .i_switch_stall(ev[12]),
		.i_switch_possible_mispredict(ev[13]),
		.i_switch_mispredict(ev[14]), .i_func_unit_stall(ev[15]),
		.i_noncache_stall(ev[16]), .i_imem_op_issued(ev[17]),
		.i_static_output_stall(ev[18]),
		.i_general_net_output_stall(ev[19]),
		.i_memory_net_output_stall(ev[20]),
		.i_static_input_stall(ev[21]),
		.i_second_static_input_stall(ev[22]),
		.i_general_net_input_stall(ev[23]),
		.i_memory_net_input_stall(ev[24]),
		.i_general_proc_port_count(ev[25]),
		.i_memory_proc_port_count(ev[26]),
		.i_general_west_port_count(ev[27]),
		.i_memory_west_port_count(ev[28]),
		.i_general_south_port_count(ev[29]),
		.i_memory_south_port_count(ev[30]),
		.i_general_east_port_count(ev[31]),
		.i_memory_east_port_count(ev[32]),
		.o_rd_data(rd), .o_trigger_flags(flags),
		.o_exception_pending_bits_counter(irq)
	);
	// verdict and end of run
	task stop_test;
	begin
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
	endtask
	// one compare for every value seen at the ports
	task chk(input string nm, input [31:0] exp, input [31:0] got);
	begin
		compares = compares + 1;
		if (got !== exp)
		begin
			n_fail = n_fail + 1;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	end
	endtask
	// software write, one cycle, entered at a falling edge
	task wr(input [3:0] k, input [31:0] d);
	begin
		wr_en = 1'b1;
		wr_idx = k;
		wr_data = d;
		@(negedge clk);
		wr_en = 1'b0;
	end
	endtask
	// one strobe, then a cycle for the read path to settle
	task pl(input integer b);
	begin
		req = 33'h1 << b;
		@(negedge clk);
		req = 33'h0;
		@(negedge clk);
	end
	endtask
	// counter k with select bit sp; s bit0 single-pc miss, bit1 disabled
	task cc(input integer k, input integer sp, input integer b,
		input integer s, input [31:0] e);
	begin
		sel = 32'h1 << sp;
		cfg = (s[1] ? 32'h0 : (32'h1 << (16 + k))) | (s[0] ? 32'h3 : 32'h0);
		rd_idx = k[3:0];
		pc = 32'h0;
		wr(k[3:0], 32'h100);
		pl(b);
		chk("count", 32'h100 - e, rd);
	end
	endtask
	// wrap of counter 11 through a port source, then pc capture
	task under;
	begin
		sel = 32'h18;
		cfg = 32'h08000000;
		rd_idx = 4'hB;
		pc = 32'h12344;
		wr(4'hB, 32'h1);
		pl(25);
		pl(25);
		chk("wrap", 32'hFFFFFFFF, rd);
		chk("trig", 32'h800, flags);
		chk("irq", 32'h1, irq);
		pl(15);
		chk("pcf", 32'h48D1FFFE, rd);
		wr(4'hB, 32'h5);
		chk("clear", 32'h0, flags);
		@(negedge clk);
		chk("irq", 32'h0, irq);
		chk("rd", 32'h5, rd);
	end
	endtask
	// clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// watchdog, far beyond the 117 cycles the run needs
	initial
	begin
		#100000;
		n_fail = n_fail + 1;
		stop_test;
	end
	// main sequence
	initial
	begin
		nrst = 1'b0;
		wr_en = 1'b0;
		wr_idx = 4'h0;
		wr_data = 32'h0;
		rd_idx = 4'h0;
		sel = 32'h0;
		cfg = 32'h0;
		pc = 32'h0;
		req = 33'h0;
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		chk("rst", 32'h0, {rd[15:0] | rd[31:16], flags});
		chk("rst_irq", 32'h0, irq);
		under;
		cc(0, 25, 0, 0, 1);
		cc(0, 31, 40, 0, 1);
		cc(1, 31, 1, 0, 1);
		cc(2, 31, 2, 0, 1);
		cc(3, 31, 3, 0, 1);
		cc(4, 31, 4, 0, 1);
		cc(4, 31, 5, 0, 0);
		cc(4, 0, 5, 0, 1);
		cc(4, 0, 4, 0, 0);
		cc(5, 31, 7, 0, 1);
		cc(5, 1, 7, 0, 0);
		cc(5, 1, 8, 0, 1);
		cc(6, 31, 9, 0, 1);
		cc(6, 2, 10, 0, 1);
		cc(6, 2, 9, 0, 0);
		cc(7, 31, 12, 0, 1);
		cc(8, 31, 13, 0, 1);
		cc(9, 31, 14, 0, 1);
		cc(10, 31, 40, 0, 32'h80);
		cc(11, 23, 11, 0, 1);
		cc(11, 5, 26, 0, 1);
		cc(11, 4, 15, 0, 0);
		cc(12, 6, 16, 0, 1);
		cc(12, 8, 28, 0, 1);
		cc(13, 9, 17, 0, 1);
		cc(13, 24, 11, 0, 1);
		cc(13, 10, 29, 0, 1);
		cc(14, 13, 19, 0, 1);
		cc(14, 16, 32, 0, 1);
		cc(15, 17, 21, 0, 1);
		cc(15, 20, 24, 0, 1);
		cc(1, 31, 1, 1, 0);
		cc(7, 31, 12, 1, 1);
		cc(2, 31, 2, 2, 0);
		stop_test;
	end
endmodule // test_tile_event_counter_array
